// ---- inc/rwp_pkg.sv ----
/*
  Constants and types for the two-wire bus master that drives the row-write slave port.
  Assumes a 50 MHz system clock; the serial clock is made from it by division.
*/
`default_nettype none

package rwp_pkg;

  // ----------------------------------------------------------------------
  // Bus addressing
  // ----------------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h50;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam int ROW_BYTES = 4;
  localparam int ROW_OFF_W = 2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_NS = 20;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_NS = SCL_PERIOD_NS / 4;
  localparam int SCL_QUARTER_CYC = (QUARTER_NS / SYS_CLK_NS) < 1 ? 1 : (QUARTER_NS / SYS_CLK_NS);
  localparam int BUS_FREE_NS = 5000;
  localparam logic [3:0] BUS_FREE_QTR = 4'((BUS_FREE_NS + QUARTER_NS - 1) / QUARTER_NS);
  localparam int POLL_TRIES = 255;

  // ----------------------------------------------------------------------
  // Bit positions inside one byte slot and quarters of one bit
  // ----------------------------------------------------------------------
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] Q_LOW_A = 2'h0;
  localparam logic [1:0] Q_LOW_B = 2'h1;
  localparam logic [1:0] Q_HIGH_A = 2'h2;
  localparam logic [1:0] Q_HIGH_B = 2'h3;

  // ----------------------------------------------------------------------
  // Sequencer types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_START, S_XFER, S_STOP, S_WAIT} rwp_state_e;
  typedef enum logic [2:0] {P_ADDR_W, P_MEM, P_WDATA, P_ADDR_R, P_RDATA} rwp_phase_e;

endpackage

`default_nettype wire

// ---- design/rwp_host.sv ----
/*
  Two-wire bus master for the row-write slave port: start, stop, repeated start,
  byte transfer with acknowledge, row-limited writes, reads and acknowledge polling.
  Assumes an external pull-up on the data line; the serial clock is driven push-pull.
*/
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Repeated start looks like plain start
// - Data changes only while clock low
// - Eight bits MSB first, then acknowledge
// - Ninth bit: zero acknowledges, one refuses
// - Master refuses the last read byte
// - Write: second byte is memory address
// - Master stops at row end, drops the rest
// - Master re-polls address up to POLL_TRIES times until acknowledged
// - Dummy write then repeated start reads
module rwp_host #(
  parameter int SCL_QUARTER_CYC = rwp_pkg::SCL_QUARTER_CYC,
  parameter logic [7:0] POLL_TRIES = 8'(rwp_pkg::POLL_TRIES)
) (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Request
  input wire logic i_req,
  input wire logic i_rnw,
  input wire logic i_set_addr,
  input wire logic i_poll,
  input wire logic [7:0] i_mem_addr,
  input wire logic [7:0] i_count,
  input wire logic [31:0] i_wdata,
  // Answer
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  // Bus pins
  output logic o_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_module_select_n
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  localparam int QW = $clog2(SCL_QUARTER_CYC + 1);

  // Slave address byte with direction bit
  function automatic logic [7:0] addr_byte(input logic rd);
    addr_byte = {rwp_pkg::SLAVE_ADDR, rd};
  endfunction

  // Bytes left in the row from a memory address
  function automatic logic [8:0] row_room(input logic [7:0] a);
    row_room = 9'(rwp_pkg::ROW_BYTES) - 9'(a[rwp_pkg::ROW_OFF_W-1:0]);
  endfunction

  // ----------------------------------------------------------------------
  // Reset release and data-line synchroniser
  // ----------------------------------------------------------------------
  logic rst_meta_r, rst_n;
  logic sda_meta_r, sda_sync_r;

  // Reset is applied at once and released through two flops
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Two flops before the data line is read
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
    end else if (i_ce) begin
      sda_meta_r <= i_sda;
      sda_sync_r <= sda_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // Quarter-bit timer
  // ----------------------------------------------------------------------
  rwp_pkg::rwp_state_e st_r, st_nxt;
  logic [QW-1:0] qcnt_r, qcnt_nxt;
  logic tick;

  assign tick = (qcnt_r == QW'(SCL_QUARTER_CYC - 1));

  // Divides the system clock into quarters of a serial bit
  always_comb begin
    qcnt_nxt = qcnt_r;
    if (st_r == rwp_pkg::S_IDLE || tick) begin
      qcnt_nxt = '0;
    end else begin
      qcnt_nxt = qcnt_r + QW'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      qcnt_r <= '0;
    end else if (i_ce) begin
      qcnt_r <= qcnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------------
  rwp_pkg::rwp_phase_e ph_r, ph_nxt;
  logic [1:0] q_r, q_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt, mem_r, mem_nxt, tries_r, tries_nxt;
  logic [8:0] cnt_r, cnt_nxt, len_r, len_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic rnw_r, rnw_nxt, poll_r, poll_nxt, retry_r, retry_nxt;
  logic scl_nxt, sda_oe_nxt, sel_n_nxt, busy_nxt, done_nxt, nack_nxt, rdv_nxt;
  logic [7:0] rdd_nxt;
  logic last, ack;

  assign last = (cnt_r + 9'h001 == len_r);
  assign ack = !sda_sync_r;

  // Next values of the whole transfer, advanced once per quarter
  always_comb begin
    st_nxt = st_r;
    ph_nxt = ph_r;
    q_nxt = q_r;
    bit_nxt = bit_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    mem_nxt = mem_r;
    tries_nxt = tries_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    wd_nxt = wd_r;
    rnw_nxt = rnw_r;
    poll_nxt = poll_r;
    retry_nxt = retry_r;
    scl_nxt = o_scl;
    sda_oe_nxt = o_sda_oe;
    sel_n_nxt = o_module_select_n;
    busy_nxt = o_busy;
    nack_nxt = o_nack;
    rdd_nxt = o_rd_data;
    done_nxt = 1'b0;
    rdv_nxt = 1'b0;
    if (st_r != rwp_pkg::S_IDLE && tick) begin
      q_nxt = q_r + 2'h1;
    end
    unique case (st_r)
      rwp_pkg::S_IDLE: begin
        if (i_req) begin
          st_nxt = rwp_pkg::S_START;
          q_nxt = rwp_pkg::Q_LOW_A;
          busy_nxt = 1'b1;
          nack_nxt = 1'b0;
          sel_n_nxt = 1'b0;
          rnw_nxt = i_rnw;
          poll_nxt = i_poll;
          mem_nxt = i_mem_addr;
          wd_nxt = i_wdata;
          cnt_nxt = '0;
          tries_nxt = '0;
          retry_nxt = 1'b0;
          // Read without address byte serves the counter as it stands
          ph_nxt = (i_rnw && !i_set_addr) ? rwp_pkg::P_ADDR_R : rwp_pkg::P_ADDR_W;
          tx_nxt = addr_byte(i_rnw && !i_set_addr);
          len_nxt = {1'b0, i_count} + 9'h001;
          // Writes never cross the row end, so the slave never wraps
          if (!i_rnw && ({1'b0, i_count} + 9'h001 > row_room(i_mem_addr))) begin
            len_nxt = row_room(i_mem_addr);
          end
        end
      end
      rwp_pkg::S_START: begin
        if (tick) begin
          unique case (q_r)
            rwp_pkg::Q_LOW_A: sda_oe_nxt = 1'b0;
            rwp_pkg::Q_LOW_B: scl_nxt = 1'b1;
            rwp_pkg::Q_HIGH_A: sda_oe_nxt = 1'b1;
            rwp_pkg::Q_HIGH_B: begin
              scl_nxt = 1'b0;
              bit_nxt = '0;
              st_nxt = rwp_pkg::S_XFER;
            end
          endcase
        end
      end
      rwp_pkg::S_XFER: begin
        if (tick) begin
          unique case (q_r)
            rwp_pkg::Q_LOW_A: begin
              // Data set a quarter after the falling clock edge
              if (bit_r != rwp_pkg::ACK_BIT) begin
                sda_oe_nxt = (ph_r == rwp_pkg::P_RDATA) ? 1'b0 : !tx_r[7];
              end else begin
                sda_oe_nxt = (ph_r == rwp_pkg::P_RDATA) ? !last : 1'b0;
              end
            end
            rwp_pkg::Q_LOW_B: scl_nxt = 1'b1;
            rwp_pkg::Q_HIGH_A: scl_nxt = 1'b1;
            rwp_pkg::Q_HIGH_B: begin
              scl_nxt = 1'b0;
              bit_nxt = '0;
              if (bit_r != rwp_pkg::ACK_BIT) begin
                // Sampled late in the high phase, after the slave set it up
                rx_nxt = {rx_r[6:0], sda_sync_r};
                tx_nxt = {tx_r[6:0], 1'b1};
                bit_nxt = bit_r + 4'h1;
              end else begin
                unique case (ph_r)
                  rwp_pkg::P_ADDR_W, rwp_pkg::P_ADDR_R: begin
                    if (!ack && poll_r && tries_r != POLL_TRIES) begin
                      tries_nxt = tries_r + 8'h01;
                      retry_nxt = 1'b1;
                      tx_nxt = addr_byte(ph_r == rwp_pkg::P_ADDR_R);
                      st_nxt = rwp_pkg::S_STOP;
                    end else if (!ack) begin
                      nack_nxt = 1'b1;
                      st_nxt = rwp_pkg::S_STOP;
                    end else if (ph_r == rwp_pkg::P_ADDR_W) begin
                      ph_nxt = rwp_pkg::P_MEM;
                      tx_nxt = mem_r;
                    end else begin
                      ph_nxt = rwp_pkg::P_RDATA;
                    end
                  end
                  rwp_pkg::P_MEM: begin
                    if (!ack) begin
                      nack_nxt = 1'b1;
                      st_nxt = rwp_pkg::S_STOP;
                    end else if (rnw_r) begin
                      ph_nxt = rwp_pkg::P_ADDR_R;
                      tx_nxt = addr_byte(rwp_pkg::DIR_READ);
                      st_nxt = rwp_pkg::S_START;
                    end else begin
                      ph_nxt = rwp_pkg::P_WDATA;
                      tx_nxt = wd_r[31:24];
                      wd_nxt = {wd_r[23:0], 8'h00};
                    end
                  end
                  rwp_pkg::P_WDATA: begin
                    cnt_nxt = cnt_r + 9'h001;
                    tx_nxt = wd_r[31:24];
                    wd_nxt = {wd_r[23:0], 8'h00};
                    if (!ack) begin
                      nack_nxt = 1'b1;
                      st_nxt = rwp_pkg::S_STOP;
                    end else if (last) begin
                      st_nxt = rwp_pkg::S_STOP;
                    end
                  end
                  rwp_pkg::P_RDATA: begin
                    rdv_nxt = 1'b1;
                    rdd_nxt = rx_r;
                    cnt_nxt = cnt_r + 9'h001;
                    if (last) begin
                      st_nxt = rwp_pkg::S_STOP;
                    end
                  end
                endcase
              end
            end
          endcase
        end
      end
      rwp_pkg::S_STOP: begin
        if (tick) begin
          unique case (q_r)
            rwp_pkg::Q_LOW_A: sda_oe_nxt = 1'b1;
            rwp_pkg::Q_LOW_B: scl_nxt = 1'b1;
            rwp_pkg::Q_HIGH_A: sda_oe_nxt = 1'b0;
            rwp_pkg::Q_HIGH_B: begin
              bit_nxt = '0;
              st_nxt = rwp_pkg::S_WAIT;
            end
          endcase
        end
      end
      rwp_pkg::S_WAIT: begin
        // Bus free time, then either poll again or finish
        if (tick) begin
          bit_nxt = bit_r + 4'h1;
          if (bit_r + 4'h1 >= rwp_pkg::BUS_FREE_QTR) begin
            q_nxt = rwp_pkg::Q_LOW_A;
            if (retry_r) begin
              retry_nxt = 1'b0;
              st_nxt = rwp_pkg::S_START;
            end else begin
              st_nxt = rwp_pkg::S_IDLE;
              busy_nxt = 1'b0;
              done_nxt = 1'b1;
              sel_n_nxt = 1'b1;
            end
          end
        end
      end
    endcase
  end

  // Registers of the sequencer; every output is one of them
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= rwp_pkg::S_IDLE;
      ph_r <= rwp_pkg::P_ADDR_W;
      q_r <= rwp_pkg::Q_LOW_A;
      bit_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      mem_r <= '0;
      tries_r <= '0;
      cnt_r <= '0;
      len_r <= '0;
      wd_r <= '0;
      rnw_r <= 1'b0;
      poll_r <= 1'b0;
      retry_r <= 1'b0;
      o_scl <= 1'b1;
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
      o_module_select_n <= 1'b1;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_nack <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      q_r <= q_nxt;
      bit_r <= bit_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      mem_r <= mem_nxt;
      tries_r <= tries_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      wd_r <= wd_nxt;
      rnw_r <= rnw_nxt;
      poll_r <= poll_nxt;
      retry_r <= retry_nxt;
      o_scl <= scl_nxt;
      o_sda_oe <= sda_oe_nxt;
      o_sda_out <= 1'b0; // Line is only ever pulled low
      o_module_select_n <= sel_n_nxt;
      o_busy <= busy_nxt;
      o_done <= done_nxt;
      o_nack <= nack_nxt;
      o_rd_valid <= rdv_nxt;
      o_rd_data <= rdd_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_start_done;
    (st_r == rwp_pkg::S_START) ##1 (st_r == rwp_pkg::S_XFER);
  endsequence

  sequence s_mem_acked_read;
    (st_r == rwp_pkg::S_XFER && ph_r == rwp_pkg::P_MEM && bit_r == rwp_pkg::ACK_BIT
      && tick && q_r == rwp_pkg::Q_HIGH_B && ack && rnw_r && i_ce);
  endsequence

  a_start_only_in: assert property (
    o_scl && $past(o_scl) && $rose(o_sda_oe) |-> st_r == rwp_pkg::S_START)
    else $error("data pulled low under high clock outside start");

  a_stop_only_in: assert property (
    o_scl && $past(o_scl) && $fell(o_sda_oe) |-> st_r == rwp_pkg::S_WAIT || st_r == rwp_pkg::S_STOP)
    else $error("data released under high clock outside stop");

  a_data_stable_high: assert property (
    st_r == rwp_pkg::S_XFER && o_scl && $past(o_scl) && $past(st_r) == rwp_pkg::S_XFER
      |-> $stable(o_sda_oe))
    else $error("data changed while clock high");

  a_addr_first_byte: assert property (
    s_start_done |-> tx_r[7:1] == rwp_pkg::SLAVE_ADDR && bit_r == 4'h0)
    else $error("first byte after start is not the slave address");

  a_read_final_nack: assert property (
    st_r == rwp_pkg::S_XFER && ph_r == rwp_pkg::P_RDATA && bit_r == rwp_pkg::ACK_BIT
      && o_scl && last |-> !o_sda_oe)
    else $error("last read byte was acknowledged");

  a_read_more_ack: assert property (
    st_r == rwp_pkg::S_XFER && ph_r == rwp_pkg::P_RDATA && bit_r == rwp_pkg::ACK_BIT
      && o_scl && !last |-> o_sda_oe)
    else $error("non-final read byte not acknowledged");

  a_repeat_start: assert property (
    s_mem_acked_read |=> st_r == rwp_pkg::S_START && ph_r == rwp_pkg::P_ADDR_R)
    else $error("dummy write not followed by repeated start");

  a_row_limit: assert property (
    ph_r == rwp_pkg::P_WDATA && st_r == rwp_pkg::S_XFER
      |-> cnt_r < len_r && len_r + 9'(mem_r[rwp_pkg::ROW_OFF_W-1:0]) <= 9'(rwp_pkg::ROW_BYTES))
    else $error("write runs past the row end");

  a_select_held: assert property (
    st_r != rwp_pkg::S_IDLE |-> !o_module_select_n && o_busy)
    else $error("select released during a transfer");

  a_bit_count: assert property (
    st_r == rwp_pkg::S_XFER |-> bit_r <= rwp_pkg::ACK_BIT)
    else $error("byte slot longer than nine bits");

  a_done_single: assert property (
    o_done |-> !o_busy ##1 !o_done)
    else $error("done longer than one cycle");

endmodule

`default_nettype wire

// ---- tb/rwp_slave_model.sv ----
/*
  Behavioural two-wire slave port: address match, memory counter, row-limited writes
  with commit at stop, busy refusal while a row programs, and reads.
  Assumes the bench resolves the data line as a wired-AND with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none

module rwp_slave_model #(
  parameter int PROG_NS = 6000
) (
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_module_select_n,
  // Data line pull-down
  output logic o_pull
);
  logic [7:0] mem [256];
  logic [7:0] row [4];
  logic [7:0] shreg;
  logic [7:0] ptr;
  logic [7:0] rbyte;
  logic [3:0] bitcnt;
  logic rw;
  logic first;
  logic dirty;
  logic last_nack;
  int st;
  int n_start;
  int n_stop;
  int n_busy;
  realtime busy_until;

  // Known contents and idle bus state
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    o_pull = 1'b0;
    st = 0;
    n_start = 0;
    n_stop = 0;
    n_busy = 0;
    dirty = 1'b0;
    last_nack = 1'b0;
    busy_until = 0;
  end

  // Start or repeated start; selection decided here
  always @(negedge i_sda) begin
    if (i_scl === 1'b1) begin
      n_start++;
      first = 1'b1;
      bitcnt = 4'h0;
      o_pull = 1'b0;
      st = (i_module_select_n === 1'b0) ? 1 : 0;
    end
  end

  // Stop: release, then program the whole row
  always @(posedge i_sda) begin
    if (i_scl === 1'b1) begin
      n_stop++;
      st = 0;
      o_pull = 1'b0;
      if (dirty) begin
        for (int k = 0; k < 4; k++) mem[{ptr[7:2], 2'(k)}] = row[k];
        busy_until = $realtime + PROG_NS;
        dirty = 1'b0;
      end
    end
  end

  // Sample on the rising clock edge
  always @(posedge i_scl) begin
    if (st != 0 && st != 4 && bitcnt < 4'h8) shreg = {shreg[6:0], i_sda};
    if (st == 4 && bitcnt == 4'h8) last_nack = i_sda;
  end

  // Drive or release after the falling clock edge
  always @(negedge i_scl) begin
    if (st == 0 || first) begin
      first = 1'b0;
    end else if (bitcnt == 4'h7) begin
      bitcnt = 4'h8;
      o_pull = 1'b0;
      if (st == 1) begin
        rw = shreg[0];
        if (shreg[7:1] != 7'h50) begin
          st = 0;
        end else if ($realtime < busy_until) begin
          n_busy++;
          st = 0;
        end else begin
          o_pull = 1'b1;
        end
      end else if (st == 2) begin
        ptr = shreg;
        for (int k = 0; k < 4; k++) row[k] = mem[{shreg[7:2], 2'(k)}];
        o_pull = 1'b1;
      end else if (st == 3) begin
        row[ptr[1:0]] = shreg;
        dirty = 1'b1;
        ptr[1:0] = ptr[1:0] + 2'h1;
        o_pull = 1'b1;
      end
    end else if (bitcnt == 4'h8) begin
      bitcnt = 4'h0;
      o_pull = 1'b0;
      if (st == 1) st = rw ? 4 : 2;
      else if (st == 2) st = 3;
      else if (st == 4 && last_nack) st = 0;
      if (st == 4) begin
        rbyte = mem[ptr];
        ptr = (ptr == 8'hFF) ? 8'h80 : ptr + 8'h01;
        o_pull = ~rbyte[7];
      end
    end else begin
      bitcnt++;
      if (st == 4) o_pull = ~rbyte[3'(4'h7 - bitcnt)];
    end
  end
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for the two-wire master driving the row-write slave model.
  Assumes a 50 MHz clock; the data line is resolved here with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_ce = 1'b1;
  logic i_req = 1'b0;
  logic i_rnw = 1'b0;
  logic i_set_addr = 1'b0;
  logic i_poll = 1'b0;
  logic [7:0] i_mem_addr = 8'h00;
  logic [7:0] i_count = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic o_busy, o_done, o_nack, o_rd_valid, o_scl, o_sda_oe, o_module_select_n, o_sda_out;
  logic [7:0] o_rd_data;
  logic slave_pull;
  wire logic sda_line;
  logic [7:0] rd_q [8];
  int nrd;
  int sel_bad = 0;
  int fails = 0;
  int n_tests = 0;

  // ----------------------------------------------------------------------
  // Clock, line and instances
  // ----------------------------------------------------------------------
  always #10 i_sys_clk = ~i_sys_clk;
  // Wired-AND with pull-up
  assign sda_line = ~(o_sda_oe | slave_pull);

  rwp_host #(.SCL_QUARTER_CYC(4), .POLL_TRIES(8'h03)) i_rwp_host (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_req(i_req), .i_rnw(i_rnw),
    .i_set_addr(i_set_addr), .i_poll(i_poll), .i_mem_addr(i_mem_addr), .i_count(i_count),
    .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done), .o_nack(o_nack),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_scl(o_scl), .i_sda(sda_line),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_module_select_n(o_module_select_n));

  rwp_slave_model #(.PROG_NS(6000)) i_rwp_slave_model (
    .i_scl(o_scl), .i_sda(sda_line), .i_module_select_n(o_module_select_n),
    .o_pull(slave_pull));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  function automatic logic [7:0] ini(input int a);
    return 8'(a) ^ 8'h5A;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One request, then collect read bytes until done
  task automatic run(input logic rnw, input logic sa, input logic poll,
                     input logic [7:0] addr, input logic [7:0] cnt, input logic [31:0] wd);
    int k;
    @(posedge i_sys_clk);
    #1;
    i_req = 1'b1;
    i_rnw = rnw;
    i_set_addr = sa;
    i_poll = poll;
    i_mem_addr = addr;
    i_count = cnt;
    i_wdata = wd;
    @(posedge i_sys_clk);
    #1;
    i_req = 1'b0;
    nrd = 0;
    for (k = 0; k < 20000; k++) begin
      if (o_rd_valid === 1'b1 && nrd < 8) begin
        rd_q[nrd] = o_rd_data;
        nrd++;
      end
      if (o_busy === 1'b1 && o_module_select_n !== 1'b0) sel_bad++;
      if (o_done === 1'b1) break;
      @(posedge i_sys_clk);
      #1;
    end
    if (k == 20000) begin
      fails++;
      $display("[ERR] %0t no completion", $time);
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_write_read();
    int s0, p0, b0;
    chk(32'({o_scl, o_sda_oe, o_module_select_n, o_busy, o_sda_out}), 32'h0000_0014, "idle pins");
    s0 = i_rwp_slave_model.n_start;
    p0 = i_rwp_slave_model.n_stop;
    run(1'b0, 1'b0, 1'b1, 8'h05, 8'h00, 32'hC300_0000);
    chk(32'(o_nack), 32'h0000_0000, "write refused");
    chk(32'(i_rwp_slave_model.n_start - s0), 32'h0000_0001, "write starts");
    chk(32'(i_rwp_slave_model.n_stop - p0), 32'h0000_0001, "write stops");
    chk(32'(i_rwp_slave_model.mem[5]), 32'h0000_00C3, "byte stored");
    chk(32'(i_rwp_slave_model.mem[4]), 32'(ini(4)), "row neighbour");
    b0 = i_rwp_slave_model.n_busy;
    run(1'b1, 1'b1, 1'b1, 8'h05, 8'h00, 32'h0000_0000);
    chk(32'(i_rwp_slave_model.n_busy > b0), 32'h0000_0001, "busy refusal");
    chk(32'(o_nack), 32'h0000_0000, "poll result");
    chk(32'(nrd), 32'h0000_0001, "read count");
    chk(32'(rd_q[0]), 32'h0000_00C3, "read back");
    chk(32'(i_rwp_slave_model.last_nack), 32'h0000_0001, "last byte refused");
  endtask

  task automatic t_row_write();
    #7000;
    run(1'b0, 1'b0, 1'b0, 8'h10, 8'h03, 32'h1122_3344);
    for (int k = 0; k < 4; k++) begin
      chk(32'(i_rwp_slave_model.mem[8'h10 + k]), 32'(8'(32'h1122_3344 >> (24 - 8 * k))), "row");
    end
    run(1'b0, 1'b0, 1'b1, 8'h12, 8'h03, 32'hAABB_CCDD);
    chk(32'(i_rwp_slave_model.mem[8'h12]), 32'h0000_00AA, "clamp first");
    chk(32'(i_rwp_slave_model.mem[8'h13]), 32'h0000_00BB, "clamp second");
    chk(32'(i_rwp_slave_model.mem[8'h10]), 32'h0000_0011, "row start kept");
    chk(32'(i_rwp_slave_model.mem[8'h14]), 32'(ini(8'h14)), "next row kept");
    run(1'b0, 1'b0, 1'b0, 8'h20, 8'h00, 32'h9900_0000);
    chk(32'(o_nack), 32'h0000_0001, "busy abort");
    chk(32'(i_rwp_slave_model.mem[8'h20]), 32'(ini(8'h20)), "aborted write");
  endtask

  task automatic t_read_wrap();
    int s0;
    logic [2:0] frz;
    #7000;
    s0 = i_rwp_slave_model.n_start;
    run(1'b1, 1'b1, 1'b0, 8'hFE, 8'h02, 32'h0000_0000);
    chk(32'(i_rwp_slave_model.n_start - s0), 32'h0000_0002, "repeated start");
    chk(32'(nrd), 32'h0000_0003, "multi read");
    chk(32'(rd_q[0]), 32'(ini(8'hFE)), "read 0");
    chk(32'(rd_q[1]), 32'(ini(8'hFF)), "read 1");
    chk(32'(rd_q[2]), 32'(ini(8'h80)), "read wrap");
    chk(32'(i_rwp_slave_model.last_nack), 32'h0000_0001, "final refusal");
    // Current-address read, frozen by the clock enable part way through
    fork
      run(1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 32'h0000_0000);
      begin
        repeat (30) @(posedge i_sys_clk);
        #1;
        i_ce = 1'b0;
        frz = {o_scl, o_sda_oe, o_busy};
        repeat (40) @(posedge i_sys_clk);
        #1;
        chk(32'({o_scl, o_sda_oe, o_busy}), 32'(frz), "enable freeze");
        chk(32'(o_busy), 32'h0000_0001, "frozen mid transfer");
        i_ce = 1'b1;
      end
    join
    chk(32'(rd_q[0]), 32'(ini(8'h81)), "current address");
    chk(32'(sel_bad), 32'h0000_0000, "select held");
  endtask

  // ----------------------------------------------------------------------
  // Sequence, watchdog, verdict
  // ----------------------------------------------------------------------
  task automatic summarize();
    $display("n_tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge i_sys_clk);
    #1;
    i_rstn = 1'b1;
    repeat (4) @(posedge i_sys_clk);
    #1;
    t_write_read();
    t_row_write();
    t_read_wrap();
    summarize();
  end

  // Cut a hang short well past the expected run time
  initial begin
    #200_000;
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
endmodule

`default_nettype wire
